// ===== bench/supervisor_assertions.sv
// supervisor_assertions.sv: timing checks on the supervisor top-level ports
// assumes one clock domain; bound to every supervisor instance
`timescale 1ns/1ps
`default_nettype none
// ****************
// checker
// ****************
module supervisor_checker #(
    parameter int RESET_PULSE_CYCLES  = 50,
    parameter int KICK_TIMEOUT_CYCLES = 100,
    parameter int AUX_FILTER_CYCLES   = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_supply_ok,
    input wire logic i_pushbutton_reset_n,
    input wire logic i_kick_input,
    input wire logic i_kick_floating,
    input wire logic i_aux_supply_sense,
    input wire logic o_sys_reset_n,
    input wire logic o_sys_reset,
    input wire logic o_sys_reset_opendrain_n_o,
    input wire logic o_sys_reset_opendrain_n_oe,
    input wire logic o_kick_timeout_n,
    input wire logic o_aux_supply_fail_n
);
    int   good = 0, sup_hi = 0, btn_lo = 0, idle = 0, aux_run = 0;
    logic kick_q = 1'b0, aux_q = 1'b0;
    // run lengths of raw inputs; not reset, so they span a reset
    always @(posedge i_clk_sys)
    begin
        kick_q  <= i_kick_input;
        aux_q   <= i_aux_supply_sense;
        good    <= (i_supply_ok && i_pushbutton_reset_n) ? good + 1 : 0;
        sup_hi  <= i_supply_ok ? sup_hi + 1 : 0;
        btn_lo  <= i_pushbutton_reset_n ? 0 : btn_lo + 1;
        aux_run <= (i_aux_supply_sense != aux_q) ? 0 : aux_run + 1;
        idle    <= (i_kick_input != kick_q || i_kick_floating || !o_sys_reset_n) ? 0 : idle + 1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_inv; o_sys_reset == !o_sys_reset_n; endproperty
    a_inv: assert property (p_inv) else $error("high reset not inverse");
    property p_od; o_sys_reset_opendrain_n_oe == o_sys_reset && !o_sys_reset_opendrain_n_o;
    endproperty
    a_od: assert property (p_od) else $error("open drain timing");
    property p_sup; $fell(i_supply_ok) |-> ##[1:8] (!o_sys_reset_n && !o_kick_timeout_n);
    endproperty
    a_sup: assert property (p_sup) else $error("supply low not seen");
    property p_rec; $rose(i_supply_ok) |-> ##[1:8] o_kick_timeout_n; endproperty
    a_rec: assert property (p_rec) else $error("timeout out not back");
    property p_rel; $rose(o_sys_reset_n) |->
        good >= RESET_PULSE_CYCLES && good <= RESET_PULSE_CYCLES + 40; endproperty
    a_rel: assert property (p_rel) else $error("release delay");
    // the low run is cleared on release, so look back to when the filter decided
    property p_btn; $fell(o_sys_reset_n) && sup_hi > 10 |-> $past(btn_lo, 3) >= 15; endproperty
    a_btn: assert property (p_btn) else $error("button too short");
    property p_kto; $fell(o_kick_timeout_n) && sup_hi > 10 |-> idle >= KICK_TIMEOUT_CYCLES;
    endproperty
    a_kto: assert property (p_kto) else $error("early timeout");
    property p_hold; $rose(o_kick_timeout_n) && sup_hi > 10 |-> idle < 20; endproperty
    a_hold: assert property (p_hold) else $error("timeout left early");
    property p_aux; $changed(o_aux_supply_fail_n) |->
        o_aux_supply_fail_n == i_aux_supply_sense && aux_run >= AUX_FILTER_CYCLES; endproperty
    a_aux: assert property (p_aux) else $error("aux fail filter");
    c_kto: cover property ($fell(o_kick_timeout_n) && sup_hi > 10);
    c_rel: cover property ($rose(o_sys_reset_n));
    c_aux: cover property ($changed(o_aux_supply_fail_n));
endmodule
bind supply_supervisor_reset_watchdog supervisor_checker #(
    .RESET_PULSE_CYCLES (RESET_PULSE_CYCLES),
    .KICK_TIMEOUT_CYCLES(KICK_TIMEOUT_CYCLES),
    .AUX_FILTER_CYCLES  (AUX_FILTER_CYCLES)
) chk (.*);
`default_nettype wire

// ===== bench/supervisor_host_model.sv
// supervisor_host_model.sv: the supervised processor, kicking the watchdog
// assumes the bench steers it; kick changes at falling edges only
`timescale 1ns/1ps
`default_nettype none
// ****************
// processor model
// ****************
module supervisor_host_model #(
    parameter int PERIOD = 40
) (
    input  wire logic i_clk_sys,
    input  wire logic i_run,
    input  wire logic i_float,
    input  wire logic i_pulse,
    output logic      o_kick,
    output logic      o_floating
);
    int   gap;
    logic run_q;
    logic float_q;
    logic kick_lvl;
    initial gap = 0;
    initial run_q = 1'b0;
    initial float_q = 1'b0;
    initial kick_lvl = 1'b0;
    // controls taken at the rising edge, so the falling-edge drive never races the bench
    always @(posedge i_clk_sys)
    begin
        run_q   <= i_run;
        float_q <= i_float;
    end
    // period stays well under the timeout; a released line changes every cycle
    always @(negedge i_clk_sys)
    begin
        gap <= (gap + 1) % PERIOD;
        if (float_q)
            kick_lvl <= ~kick_lvl;
        else if (run_q && gap == 0)
            kick_lvl <= ~kick_lvl;
    end
    // a short bench pulse rides on top of the kick level
    assign o_kick = kick_lvl ^ i_pulse;
    assign o_floating = i_float;
endmodule
`default_nettype wire

// ===== bench/supply_supervisor_reset_watchdog_tb.sv
// supply_supervisor_reset_watchdog_tb.sv: self-checking supervisor bench
// assumes short counts: pulse 50, timeout 100, aux filter 20 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %b seen %b", nm, e, g); end end
// ****************
// bench top
// ****************
module supply_supervisor_reset_watchdog_tb;
    logic clk_sys = 1'b0;
    logic rst_n, supply, btn_n, aux, run, flt, link, pulse;
    wire  kick, kick_flt, reset_n, reset_hi, od_o, od_oe, kto_n, aux_fail_n;
    wire  pb_n = btn_n & (~link | kto_n); // optional timeout-to-button strap
    int   bad_count = 0, comparisons = 0;
    always #5 clk_sys = ~clk_sys;
    supply_supervisor_reset_watchdog #(
        .RESET_PULSE_CYCLES (50),
        .KICK_TIMEOUT_CYCLES(100),
        .AUX_FILTER_CYCLES  (20)
    ) DUT (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_supply_ok(supply),
        .i_pushbutton_reset_n(pb_n), .i_kick_input(kick), .i_kick_floating(kick_flt),
        .i_aux_supply_sense(aux), .o_sys_reset_n(reset_n), .o_sys_reset(reset_hi),
        .o_sys_reset_opendrain_n_o(od_o), .o_sys_reset_opendrain_n_oe(od_oe),
        .o_kick_timeout_n(kto_n), .o_aux_supply_fail_n(aux_fail_n)
    );
    supervisor_host_model #(.PERIOD(40)) HOST (
        .i_clk_sys(clk_sys), .i_run(run), .i_float(flt), .i_pulse(pulse),
        .o_kick(kick), .o_floating(kick_flt)
    );
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // release lands about pulse plus a few sync cycles after supply good
    task automatic t_power_up;
        `CHK("reset_n supply down", 1'b0, reset_n)
        supply = 1'b1;
        cyc(45);
        `CHK("reset_n in delay", 1'b0, reset_n)
        cyc(20);
        `CHK("reset_n released", 1'b1, reset_n)
        `CHK("open drain idle", 1'b0, od_oe)
        `CHK("active high idle", 1'b0, reset_hi)
        `CHK("open drain data", 1'b0, od_o)
    endtask
    // second dip lands inside the pulse, so the delay must start again
    task automatic t_brownout;
        supply = 1'b0;
        cyc(10);
        `CHK("reset_n brownout", 1'b0, reset_n)
        `CHK("timeout_n brownout", 1'b0, kto_n)
        supply = 1'b1;
        cyc(8);
        `CHK("timeout_n recovers", 1'b1, kto_n)
        cyc(17);
        supply = 1'b0;
        cyc(3);
        supply = 1'b1;
        cyc(40);
        `CHK("reset_n stretched", 1'b0, reset_n)
        cyc(25);
        `CHK("reset_n after stretch", 1'b1, reset_n)
    endtask
    task automatic t_button;
        btn_n = 1'b0;
        cyc(14);
        btn_n = 1'b1;
        cyc(30);
        `CHK("short press ignored", 1'b1, reset_n)
        btn_n = 1'b0;
        cyc(15);
        btn_n = 1'b1;
        cyc(15);
        `CHK("long press", 1'b0, reset_n)
        cyc(45);
        `CHK("pulse after release", 1'b0, reset_n)
        cyc(40);
        `CHK("released after pulse", 1'b1, reset_n)
    endtask
    task automatic t_aux;
        `CHK("aux fail low", 1'b0, aux_fail_n)
        aux = 1'b1;
        cyc(30);
        `CHK("aux fail high", 1'b1, aux_fail_n)
        aux = 1'b0;
        cyc(10);
        aux = 1'b1;
        cyc(30);
        `CHK("aux glitch ignored", 1'b1, aux_fail_n)
        aux = 1'b0;
        cyc(30);
        `CHK("aux fail again", 1'b0, aux_fail_n)
    endtask
    task automatic t_watchdog;
        cyc(300);
        `CHK("kicked no timeout", 1'b1, kto_n)
        run = 1'b0;
        cyc(120);
        `CHK("timeout", 1'b0, kto_n)
        cyc(50);
        `CHK("timeout holds", 1'b0, kto_n)
        pulse = 1'b1;
        cyc(4);
        pulse = 1'b0;
        cyc(20);
        `CHK("short kick ignored", 1'b0, kto_n)
        pulse = 1'b1;
        cyc(5);
        pulse = 1'b0;
        cyc(20);
        `CHK("50ns kick seen", 1'b1, kto_n)
        cyc(100);
        `CHK("timeout again", 1'b0, kto_n)
        run = 1'b1;
        cyc(60);
        `CHK("kick clears", 1'b1, kto_n)
        flt = 1'b1;
        run = 1'b0;
        cyc(250);
        `CHK("floating no timeout", 1'b1, kto_n)
        flt = 1'b0;
        cyc(70);
        `CHK("driven counting", 1'b1, kto_n)
        cyc(70);
        `CHK("driven timeout", 1'b0, kto_n)
        run = 1'b1;
        cyc(60);
    endtask
    // strap timeout to button: a stall turns into a full reset pulse
    task automatic t_link;
        link = 1'b1;
        run = 1'b0;
        cyc(145);
        `CHK("timeout resets", 1'b0, reset_n)
        run = 1'b1;
        cyc(150);
        `CHK("strap released", 1'b1, reset_n)
        link = 1'b0;
    endtask
    initial
    begin
        rst_n = 1'b0;
        supply = 1'b0;
        btn_n = 1'b1;
        aux = 1'b0;
        run = 1'b1;
        flt = 1'b0;
        link = 1'b0;
        pulse = 1'b0;
        cyc(8);
        rst_n = 1'b1;
        cyc(1);
        t_power_up;
        t_brownout;
        t_button;
        t_aux;
        t_watchdog;
        t_link;
        close_out;
    end
    // the run needs about 20 us; five times that means a hang
    initial
    begin
        #100us;
        bad_count++;
        close_out;
    end
endmodule
`default_nettype wire

// ===== verilog/level_filter.sv
// level_filter.sv: three-stage synchroniser followed by a persistence filter
// assumes an asynchronous input and a single system clock
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"

module level_filter #(
    parameter logic [7:0] HOLD_CYCLES = 8'h01,
    parameter logic       INIT_LEVEL  = 1'b1
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_level
);
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic [7:0] run_cnt;
    logic [7:0] next_run_cnt;
    logic       next_level;

    // a candidate level must persist HOLD_CYCLES before it is taken;
    // stages 2 and 3 agree one cycle less than the pulse lasts, hence the extra count
    always_comb
    begin
        next_run_cnt = `SUP_DBNC_ZERO;
        next_level   = o_level;
        if (sync2 == sync3 && sync3 != o_level)
        begin
            if (run_cnt + `SUP_DBNC_TWO >= HOLD_CYCLES)
                next_level = sync3;
            else
                next_run_cnt = run_cnt + `SUP_DBNC_ONE;
        end
    end

    // sync1 feeds sync2 only
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            sync1   <= INIT_LEVEL;
            sync2   <= INIT_LEVEL;
            sync3   <= INIT_LEVEL;
            run_cnt <= `SUP_DBNC_ZERO;
            o_level <= INIT_LEVEL;
        end
        else
        begin
            sync1   <= i_async;
            sync2   <= sync1;
            sync3   <= sync2;
            run_cnt <= next_run_cnt;
            o_level <= next_level;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/supervisor_pkg.sv
// supervisor_pkg.sv: types shared by the supervisor design
// assumes supervisor_regs.svh for all numeric constants
package supervisor_pkg;

    // reset sequencer states
    typedef enum logic [1:0] {
        st_hold    = 2'b00,
        st_delay   = 2'b01,
        st_running = 2'b10
    } reset_state_t;

endpackage

// ===== verilog/supervisor_regs.svh
// supervisor_regs.svh: timing constants and polarities of the supply supervisor
// assumes a 100 MHz system clock; included by its bare name
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

`define SUP_CLK_PERIOD_NS      10
`define SUP_RESET_PULSE_MS     200
`define SUP_KICK_TIMEOUT_MS    1000
`define SUP_PUSHBUTTON_MIN_NS  150
`define SUP_KICK_PULSE_HV_NS   50
`define SUP_KICK_PULSE_LV_NS   100
`define SUP_AUX_FILTER_US      20
`define SUP_NS_PER_MS          1000000
`define SUP_NS_PER_US          1000
`define SUP_CNT_W              27
`define SUP_DBNC_W             8
`define SUP_LEVEL_ASSERTED     1'b0
`define SUP_LEVEL_RELEASED     1'b1
`define SUP_CNT_ZERO           27'h0000000
`define SUP_CNT_ONE            27'h0000001
`define SUP_DBNC_ZERO          8'h00
`define SUP_DBNC_ONE           8'h01
`define SUP_DBNC_TWO           8'h02

`endif

// ===== verilog/supply_supervisor_reset_watchdog.sv
// supply_supervisor_reset_watchdog.sv: reset sequencer, aux fail filter, watchdog
// assumes comparator results arrive as digital levels; i_rst_n is supply-good
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.svh"

module supply_supervisor_reset_watchdog
    import supervisor_pkg::*;
#(
    parameter int RESET_PULSE_CYCLES =
        `SUP_RESET_PULSE_MS * (`SUP_NS_PER_MS / `SUP_CLK_PERIOD_NS),
    parameter int KICK_TIMEOUT_CYCLES =
        `SUP_KICK_TIMEOUT_MS * (`SUP_NS_PER_MS / `SUP_CLK_PERIOD_NS),
    parameter int AUX_FILTER_CYCLES =
        `SUP_AUX_FILTER_US * (`SUP_NS_PER_US / `SUP_CLK_PERIOD_NS),
    parameter bit LOW_VOLTAGE_VARIANT = 1'b0
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_supply_ok,
    input  wire logic i_pushbutton_reset_n,
    input  wire logic i_kick_input,
    input  wire logic i_kick_floating,
    input  wire logic i_aux_supply_sense,
    output logic      o_sys_reset_n,
    output logic      o_sys_reset,
    output logic      o_sys_reset_opendrain_n_o,
    output logic      o_sys_reset_opendrain_n_oe,
    output logic      o_kick_timeout_n,
    output logic      o_aux_supply_fail_n
);
    // *****************************************************************
    // derived cycle counts
    // *****************************************************************
    // least times round up to whole cycles
    localparam logic [7:0] PB_CYCLES = 8'((`SUP_PUSHBUTTON_MIN_NS
        + `SUP_CLK_PERIOD_NS - 1) / `SUP_CLK_PERIOD_NS);
    localparam int KICK_NS = LOW_VOLTAGE_VARIANT ? `SUP_KICK_PULSE_LV_NS
                                                 : `SUP_KICK_PULSE_HV_NS;
    localparam logic [7:0] KICK_CYCLES = 8'((KICK_NS + `SUP_CLK_PERIOD_NS - 1)
        / `SUP_CLK_PERIOD_NS);
    localparam logic [26:0] RST_LAST  = 27'(RESET_PULSE_CYCLES - 1);
    localparam logic [26:0] KICK_LAST = 27'(KICK_TIMEOUT_CYCLES - 1);
    localparam logic [7:0]  AUX_HOLD  = 8'(AUX_FILTER_CYCLES);

    // *****************************************************************
    // input conditioning
    // *****************************************************************
    logic supply_ok;
    logic pushbutton_n;
    logic kick_level;
    logic kick_floating;
    logic aux_ok;

    // supply comparator: short persistence so a single-cycle glitch is not a brownout
    level_filter #(.HOLD_CYCLES(`SUP_DBNC_ONE), .INIT_LEVEL(1'b0)) u_supply (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_supply_ok),
        .o_level   (supply_ok)
    );

    // pushbutton debounce
    level_filter #(.HOLD_CYCLES(PB_CYCLES), .INIT_LEVEL(1'b1)) u_pushbutton (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_pushbutton_reset_n),
        .o_level   (pushbutton_n)
    );

    // kick input; filter length sets the shortest pulse still seen
    level_filter #(.HOLD_CYCLES(KICK_CYCLES), .INIT_LEVEL(1'b0)) u_kick (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_kick_input),
        .o_level   (kick_level)
    );

    // tri-state detector result
    level_filter #(.HOLD_CYCLES(`SUP_DBNC_ONE), .INIT_LEVEL(1'b1)) u_float (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_kick_floating),
        .o_level   (kick_floating)
    );

    // aux comparator, filtered against single event transients
    level_filter #(.HOLD_CYCLES(AUX_HOLD), .INIT_LEVEL(1'b0)) u_aux (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_aux_supply_sense),
        .o_level   (aux_ok)
    );

    // *****************************************************************
    // reset sequencer
    // *****************************************************************
    reset_state_t rst_state;
    reset_state_t next_rst_state;
    logic [26:0]  rst_cnt;
    logic [26:0]  next_rst_cnt;
    logic         hold_cond;

    // any low supply or pressed button holds reset and restarts the delay
    assign hold_cond = !supply_ok || !pushbutton_n;

    always_comb
    begin
        next_rst_state = rst_state;
        next_rst_cnt   = rst_cnt;
        unique case (rst_state)
            st_hold:
            begin
                next_rst_cnt = `SUP_CNT_ZERO;
                if (!hold_cond)
                    next_rst_state = st_delay;
            end
            st_delay:
            begin
                if (hold_cond)
                begin
                    next_rst_state = st_hold;
                    next_rst_cnt   = `SUP_CNT_ZERO;
                end
                else if (rst_cnt >= RST_LAST)
                    next_rst_state = st_running;
                else
                    next_rst_cnt = rst_cnt + `SUP_CNT_ONE;
            end
            st_running:
            begin
                next_rst_cnt = `SUP_CNT_ZERO;
                if (hold_cond)
                    next_rst_state = st_hold;
            end
            default:
            begin
                next_rst_state = st_hold;
                next_rst_cnt   = `SUP_CNT_ZERO;
            end
        endcase
    end

    // reset pin low from the first edge
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            rst_state <= st_hold;
            rst_cnt   <= `SUP_CNT_ZERO;
        end
        else
        begin
            rst_state <= next_rst_state;
            rst_cnt   <= next_rst_cnt;
        end
    end

    // *****************************************************************
    // watchdog
    // *****************************************************************
    logic        kick_prev;
    logic        next_kick_prev;
    logic [26:0] wd_cnt;
    logic [26:0] next_wd_cnt;
    logic        wd_expired;
    logic        next_wd_expired;
    logic        wd_armed;

    assign wd_armed = (rst_state == st_running) && !kick_floating;

    always_comb
    begin
        next_kick_prev  = kick_level;
        next_wd_cnt     = wd_cnt;
        next_wd_expired = wd_expired;
        if (!wd_armed || kick_level != kick_prev)
        begin
            next_wd_cnt     = `SUP_CNT_ZERO;
            next_wd_expired = 1'b0;
        end
        else if (wd_cnt >= KICK_LAST)
            next_wd_expired = 1'b1;
        else
            next_wd_cnt = wd_cnt + `SUP_CNT_ONE;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            kick_prev  <= 1'b0;
            wd_cnt     <= `SUP_CNT_ZERO;
            wd_expired <= 1'b0;
        end
        else
        begin
            kick_prev  <= next_kick_prev;
            wd_cnt     <= next_wd_cnt;
            wd_expired <= next_wd_expired;
        end
    end

    // *****************************************************************
    // output registers
    // *****************************************************************
    logic next_reset_n;
    logic next_timeout_n;

    always_comb
    begin
        next_reset_n = (next_rst_state == st_running) ? `SUP_LEVEL_RELEASED
                                                      : `SUP_LEVEL_ASSERTED;
        // supply status bypasses the release delay, unlike reset
        next_timeout_n = (supply_ok && !next_wd_expired)
                         ? `SUP_LEVEL_RELEASED : `SUP_LEVEL_ASSERTED;
    end

    // reset low, high and open-drain enable switch in the same edge; open-drain data stays 0
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_sys_reset_n             <= `SUP_LEVEL_ASSERTED;
            o_sys_reset               <= 1'b1;
            o_sys_reset_opendrain_n_o <= 1'b0;
            o_sys_reset_opendrain_n_oe <= 1'b1;
            o_kick_timeout_n          <= `SUP_LEVEL_ASSERTED;
            o_aux_supply_fail_n       <= `SUP_LEVEL_ASSERTED;
        end
        else
        begin
            o_sys_reset_n              <= next_reset_n;
            o_sys_reset                <= !next_reset_n;
            o_sys_reset_opendrain_n_o  <= 1'b0;
            o_sys_reset_opendrain_n_oe <= !next_reset_n;
            o_kick_timeout_n           <= next_timeout_n;
            o_aux_supply_fail_n        <= aux_ok;
        end
    end
endmodule
`default_nettype wire
